// *** hdl/obcl_pkg.sv ***
/*
 Constants, field layout and decode functions of the option byte loader.
 Assumes byte-wide option storage at a fixed data-memory window.
*/
// Function
// - Option bytes live in dedicated non-volatile store
// - Debug link programmer may rewrite every option byte
// - Application writes apply, except protection and boot size; those are still stored and load at next reset
// - Protection field 0xAA means unprotected, factory default
// - Boot size 0..3 protects zero to three pages
// - Boot size 0x7F..0xFF protects all 128 pages
// - Other pages unlocked only by unlock keys
// - Bit 0 auto-starts independent watchdog
// - Bit 1 stops independent watchdog in halt
// - Bit 2 auto-starts window watchdog
// - Bit 3 makes window watchdog reset on halt
// - Fast oscillator settle code gives 1/16/512/4096 cycles
// - Slow oscillator settle code gives 1/16/512/4096 cycles
// - Brownout bit 0 turns brownout reset on
// - Brownout bits 3:1 select detection threshold
// - Threshold codes 0..4 ascend in voltage
// - After reset decide bootloader or reset vector
package obcl_pkg;

  localparam logic [15:0] OB_BASE      = 16'h4800;
  localparam logic [15:0] OFS_RDP      = 16'h4800;
  localparam logic [15:0] OFS_BSZ      = 16'h4802;
  localparam logic [15:0] OFS_RSVD     = 16'h4807;
  localparam logic [15:0] OFS_DOG      = 16'h4808;
  localparam logic [15:0] OFS_OSC      = 16'h4809;
  localparam logic [15:0] OFS_BOR      = 16'h480A;
  localparam logic [15:0] OFS_BOOT_HI  = 16'h480B;
  localparam logic [15:0] OFS_BOOT_LO  = 16'h480C;
  localparam int          OB_DEPTH     = 13;
  localparam int          IDX_W        = 4;

  localparam logic [7:0]  RDP_DEFAULT  = 8'hAA;
  localparam logic [7:0]  RDP_OPEN     = 8'hAA;
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;
  localparam logic [7:0]  LOW_NIBBLE   = 8'h0F;

  localparam logic [7:0]  BSZ_ALL_MIN  = 8'h7F;
  localparam logic [7:0]  ALL_PAGES    = 8'h80;

  localparam int          IDOG_AUTO_BIT  = 0;
  localparam int          IDOG_HALT_BIT  = 1;
  localparam int          WDOG_AUTO_BIT  = 2;
  localparam int          WDOG_HALT_BIT  = 3;
  localparam int          FAST_CNT_LSB   = 0;
  localparam int          SLOW_CNT_LSB   = 2;
  localparam int          BOR_EN_BIT     = 0;
  localparam int          BOR_LVL_LSB    = 1;
  localparam logic [2:0]  BOR_LVL_MAX    = 3'h4;

  localparam int          SETTLE_W      = 13;
  localparam logic [12:0] SETTLE_C0     = 13'h0001;
  localparam logic [12:0] SETTLE_C1     = 13'h0010;
  localparam logic [12:0] SETTLE_C2     = 13'h0200;
  localparam logic [12:0] SETTLE_C3     = 13'h1000;

  typedef enum logic [2:0] {
    OBCL_LOAD = 3'b001,
    OBCL_BOOT = 3'b010,
    OBCL_RUN  = 3'b100
  } obcl_state_t;

  function automatic logic [12:0] settle_cycles(input logic [1:0] code);
    unique case (code)
      2'h0: settle_cycles = SETTLE_C0;
      2'h1: settle_cycles = SETTLE_C1;
      2'h2: settle_cycles = SETTLE_C2;
      2'h3: settle_cycles = SETTLE_C3;
    endcase
  endfunction

  function automatic logic [7:0] boot_pages(input logic [7:0] size);
    boot_pages = (size >= BSZ_ALL_MIN) ? ALL_PAGES : size;
  endfunction

  function automatic logic [2:0] level_clamp(input logic [2:0] code);
    level_clamp = (code > BOR_LVL_MAX) ? BOR_LVL_MAX : code;
  endfunction

  // Only printed option addresses map; reserved slot never stores
  function automatic logic ob_mapped(input logic [15:0] addr);
    ob_mapped = (addr == OFS_RDP) || (addr == OFS_BSZ) ||
                ((addr >= OFS_DOG) && (addr <= OFS_BOOT_LO));
  endfunction

  function automatic logic [IDX_W-1:0] ob_index(input logic [15:0] addr);
    logic [15:0] d;
    d = addr - OB_BASE;
    ob_index = d[IDX_W-1:0];
  endfunction

  // Bits that exist in each byte; the rest read as zero
  function automatic logic [7:0] ob_mask(input logic [15:0] addr);
    if ((addr == OFS_DOG) || (addr == OFS_OSC) || (addr == OFS_BOR)) begin
      ob_mask = LOW_NIBBLE;
    end else begin
      ob_mask = ~ZERO_BYTE;
    end
  endfunction

  function automatic logic [7:0] factory(input int i);
    factory = (i == 0) ? RDP_DEFAULT : ZERO_BYTE;
  endfunction

endpackage

// *** hdl/obcl_settle.sv ***
/*
 Oscillator settle counter: counts edges of an oscillator pin.
 Assumes the oscillator pin is asynchronous to clk and slower than clk/2.
*/
`timescale 1ns/1ns
module obcl_settle
  import obcl_pkg::*;
#(
  parameter int CNT_W = SETTLE_W
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       osc_pin,
  input  wire logic       enable,
  input  wire logic [1:0] code,
  output logic            ready
);

  logic [2:0]       sync_reg;
  logic [2:0]       sync_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             ready_reg;
  logic             ready_next;
  logic [CNT_W-1:0] target;

  if (CNT_W < SETTLE_W) begin
    $error("obcl_settle: CNT_W too small for longest settle");
  end

  assign target = CNT_W'(settle_cycles(code));

  always_comb begin
    sync_next = {sync_reg[1:0], osc_pin};
    cnt_next = cnt_reg;
    ready_next = ready_reg;
    if (!enable) begin
      cnt_next = '0;
      ready_next = 1'b0;
    end else if (sync_reg[1] && !sync_reg[2] && !ready_reg) begin
      cnt_next = cnt_reg + 1'b1;
      ready_next = (cnt_next >= target);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_reg <= '0;
      cnt_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
    end
  end

  assign ready = ready_reg;

endmodule

// *** hdl/obcl_store.sv ***
/*
 Non-volatile option byte array with one write and one read port.
 Assumes write requests are already decoded and masked by the loader.
*/
`timescale 1ns/1ns
module obcl_store
  import obcl_pkg::*;
#(
  parameter int DEPTH = OB_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic [7:0]       wr_data,
  input  wire logic [IDX_W-1:0] rd_idx,
  output logic      [7:0]       rd_data
);

  logic [7:0] mem [DEPTH];

  if (DEPTH != OB_DEPTH) begin
    $error("obcl_store: DEPTH must match option window");
  end

  // Factory contents; no reset since the array outlives any reset
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = factory(i);
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  assign rd_data = mem[rd_idx];

endmodule

// *** hdl/obcl_top.sv ***
/*
 Option byte loader: stores option bytes, copies them into live
 configuration after reset, decides the boot target, and serves writes
 from the debug-link programmer and from application code.
 Assumes both write ports and the read port come from logic on CLK;
 oscillator pins are asynchronous.
*/
`timescale 1ns/1ns
module obcl_top
  import obcl_pkg::*;
#(
  parameter logic [15:0] LOADER_WORD  = 16'h5A5A, // Arbitrary value
  parameter logic [7:0]  BLANK_VECTOR = 8'h00
) (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        LINK_WR,
  input  wire logic [15:0] LINK_ADDR,
  input  wire logic [7:0]  LINK_WDATA,
  input  wire logic        APP_WR,
  input  wire logic [15:0] APP_ADDR,
  input  wire logic [7:0]  APP_WDATA,
  input  wire logic        RD_EN,
  input  wire logic        RD_FROM_LINK,
  input  wire logic [15:0] RD_ADDR,
  input  wire logic [7:0]  RESET_VECTOR_BYTE,
  input  wire logic        UNLOCK_KEYS_OK,
  input  wire logic [6:0]  PAGE_QUERY,
  input  wire logic        FAST_OSC_ON,
  input  wire logic        SLOW_OSC_ON,
  input  wire logic        FAST_OSC_PIN,
  input  wire logic        SLOW_OSC_PIN,
  output logic [7:0]       RD_DATA,
  output logic             RD_VALID,
  output logic             CONFIG_LOADED,
  output logic             READOUT_PROTECT_ON,
  output logic [7:0]       BOOT_AREA_PAGES,
  output logic             PAGE_WRITE_LOCKED,
  output logic             INDEP_DOG_AUTO_START,
  output logic             INDEP_DOG_HALT_STOP,
  output logic             WINDOW_DOG_AUTO_START,
  output logic             WINDOW_DOG_HALT_RESET,
  output logic             FAST_OSC_READY,
  output logic             SLOW_OSC_READY,
  output logic             BROWNOUT_ENABLE,
  output logic [2:0]       BROWNOUT_LEVEL_SELECT,
  output logic             BOOT_DECIDED,
  output logic             BOOT_TO_LOADER
);

  obcl_state_t      state_reg;
  obcl_state_t      state_next;
  logic [IDX_W-1:0] load_idx_reg;
  logic [IDX_W-1:0] load_idx_next;

  logic             rdp_on_reg;
  logic             rdp_on_next;
  logic [7:0]       pages_reg;
  logic [7:0]       pages_next;
  logic [3:0]       dog_reg;
  logic [3:0]       dog_next;
  logic [3:0]       osc_reg;
  logic [3:0]       osc_next;
  logic             bor_en_reg;
  logic             bor_en_next;
  logic [2:0]       bor_lvl_reg;
  logic [2:0]       bor_lvl_next;
  logic [15:0]      bootw_reg;
  logic [15:0]      bootw_next;
  logic             loaded_reg;
  logic             loaded_next;
  logic             decided_reg;
  logic             decided_next;
  logic             to_loader_reg;
  logic             to_loader_next;

  logic [7:0]       rd_data_reg;
  logic [7:0]       rd_data_next;
  logic             rd_valid_reg;
  logic             rd_valid_next;
  logic             lock_reg;
  logic             lock_next;

  logic             wr_en;
  logic             wr_link;
  logic [15:0]      wr_addr;
  logic [7:0]       wr_byte;
  logic [IDX_W-1:0] st_rd_idx;
  logic [7:0]       st_rd_data;
  logic [15:0]      load_addr;
  logic [15:0]      upd_addr;
  logic [7:0]       upd_byte;
  logic             upd_en;
  logic             upd_link;

  if (OB_DEPTH > (1 << IDX_W)) begin
    $error("obcl_top: IDX_W too narrow for option window");
  end

  // Link writes win over a same-cycle application write
  always_comb begin
    wr_link = LINK_WR;
    wr_addr = LINK_WR ? LINK_ADDR : APP_ADDR;
    wr_byte = (LINK_WR ? LINK_WDATA : APP_WDATA) & ob_mask(wr_addr);
    wr_en = (LINK_WR || APP_WR) && ob_mapped(wr_addr) &&
            (state_reg != OBCL_LOAD);
  end

  assign load_addr = OB_BASE + 16'(load_idx_reg);
  assign st_rd_idx = (state_reg == OBCL_LOAD) ? load_idx_reg
                                              : ob_index(RD_ADDR);

  obcl_store #(
    .DEPTH   (OB_DEPTH)
  ) u_store (
    .clk     (CLK),
    .wr_en   (wr_en),
    .wr_idx  (ob_index(wr_addr)),
    .wr_data (wr_byte),
    .rd_idx  (st_rd_idx),
    .rd_data (st_rd_data)
  );

  // Live fields are fed from the loading walk or from a fresh write
  always_comb begin
    if (state_reg == OBCL_LOAD) begin
      upd_en = ob_mapped(load_addr);
      upd_link = 1'b1;
      upd_addr = load_addr;
      upd_byte = st_rd_data & ob_mask(load_addr);
    end else begin
      upd_en = wr_en;
      upd_link = wr_link;
      upd_addr = wr_addr;
      upd_byte = wr_byte;
    end
  end

  always_comb begin
    state_next = state_reg;
    load_idx_next = load_idx_reg;
    rdp_on_next = rdp_on_reg;
    pages_next = pages_reg;
    dog_next = dog_reg;
    osc_next = osc_reg;
    bor_en_next = bor_en_reg;
    bor_lvl_next = bor_lvl_reg;
    bootw_next = bootw_reg;
    loaded_next = loaded_reg;
    decided_next = decided_reg;
    to_loader_next = to_loader_reg;

    if (upd_en) begin
      // Protection and boot size follow link programming and the load walk, not application writes
      if (upd_addr == OFS_RDP && upd_link) begin
        rdp_on_next = (upd_byte != RDP_OPEN);
      end

      if (upd_addr == OFS_BSZ && upd_link) begin
        pages_next = boot_pages(upd_byte);
      end

      if (upd_addr == OFS_DOG) begin
        dog_next = upd_byte[3:0];
      end

      if (upd_addr == OFS_OSC) begin
        osc_next = upd_byte[3:0];
      end

      if (upd_addr == OFS_BOR) begin
        bor_en_next = upd_byte[BOR_EN_BIT];
        bor_lvl_next =
          level_clamp(upd_byte[BOR_LVL_LSB+:3]);
      end

      if (upd_addr == OFS_BOOT_HI) begin
        bootw_next[15:8] = upd_byte;
      end

      if (upd_addr == OFS_BOOT_LO) begin
        bootw_next[7:0] = upd_byte;
      end
    end

    unique case (state_reg)
      OBCL_LOAD: begin
        // Walk every slot before CONFIG_LOADED rises; live fields update as each slot is read
        if (load_idx_reg == IDX_W'(OB_DEPTH - 1)) begin
          state_next = OBCL_BOOT;
          loaded_next = 1'b1;
        end else begin
          load_idx_next = load_idx_reg + 1'b1;
        end
      end
      OBCL_BOOT: begin
        // Loader word or a blank vector picks the loader
        to_loader_next = (bootw_reg == LOADER_WORD) ||
                         (RESET_VECTOR_BYTE == BLANK_VECTOR);
        decided_next = 1'b1;
        state_next = OBCL_RUN;
      end
      OBCL_RUN: begin
        state_next = OBCL_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= OBCL_LOAD;
      load_idx_reg <= '0;
      rdp_on_reg <= 1'b1;
      pages_reg <= ZERO_BYTE;
      dog_reg <= '0;
      osc_reg <= '0;
      bor_en_reg <= 1'b0;
      bor_lvl_reg <= '0;
      bootw_reg <= '0;
      loaded_reg <= 1'b0;
      decided_reg <= 1'b0;
      to_loader_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      load_idx_reg <= load_idx_next;
      rdp_on_reg <= rdp_on_next;
      pages_reg <= pages_next;
      dog_reg <= dog_next;
      osc_reg <= osc_next;
      bor_en_reg <= bor_en_next;
      bor_lvl_reg <= bor_lvl_next;
      bootw_reg <= bootw_next;
      loaded_reg <= loaded_next;
      decided_reg <= decided_next;
      to_loader_reg <= to_loader_next;
    end
  end

  // Readback; link reads are blanked while protection is active
  always_comb begin
    rd_valid_next = RD_EN;
    rd_data_next = ZERO_BYTE;
    if (RD_EN && ob_mapped(RD_ADDR) && loaded_reg &&
        !(RD_FROM_LINK && rdp_on_reg)) begin
      rd_data_next = st_rd_data & ob_mask(RD_ADDR);
    end

    // Outside the boot area only the unlock keys release writes
    lock_next = ({1'b0, PAGE_QUERY} < pages_reg) ||
                !UNLOCK_KEYS_OK;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rd_data_reg <= ZERO_BYTE;
      rd_valid_reg <= 1'b0;
      lock_reg <= 1'b1;
    end else begin
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      lock_reg <= lock_next;
    end
  end

  obcl_settle #(
    .CNT_W   (SETTLE_W)
  ) u_fast (
    .clk     (CLK),
    .rst     (SYS_RST),
    .osc_pin (FAST_OSC_PIN),
    .enable  (FAST_OSC_ON && loaded_reg),
    .code    (osc_reg[FAST_CNT_LSB+:2]),
    .ready   (FAST_OSC_READY)
  );

  obcl_settle #(
    .CNT_W   (SETTLE_W)
  ) u_slow (
    .clk     (CLK),
    .rst     (SYS_RST),
    .osc_pin (SLOW_OSC_PIN),
    .enable  (SLOW_OSC_ON && loaded_reg),
    .code    (osc_reg[SLOW_CNT_LSB+:2]),
    .ready   (SLOW_OSC_READY)
  );

  // Settle counters, readback and boot decision held off until the copy is complete
  assign CONFIG_LOADED = loaded_reg;
  assign READOUT_PROTECT_ON = rdp_on_reg;
  assign BOOT_AREA_PAGES = pages_reg;
  assign PAGE_WRITE_LOCKED = lock_reg;
  assign INDEP_DOG_AUTO_START = dog_reg[IDOG_AUTO_BIT];
  assign INDEP_DOG_HALT_STOP = dog_reg[IDOG_HALT_BIT];
  assign WINDOW_DOG_AUTO_START = dog_reg[WDOG_AUTO_BIT];
  assign WINDOW_DOG_HALT_RESET = dog_reg[WDOG_HALT_BIT];
  assign BROWNOUT_ENABLE = bor_en_reg;
  assign BROWNOUT_LEVEL_SELECT = bor_lvl_reg;
  assign BOOT_DECIDED = decided_reg;
  assign BOOT_TO_LOADER = to_loader_reg;
  assign RD_DATA = rd_data_reg;
  assign RD_VALID = rd_valid_reg;

endmodule

// *** testbench/obcl_prog_model.sv ***
/*
 Debug-link programmer model: issues one-byte option writes.
 Assumes the loader samples the write strobe on the rising clock.
*/
`timescale 1ns/1ns
module obcl_prog_model (
  input  wire logic        clk,
  output logic             link_wr,
  output logic [15:0]      link_addr,
  output logic [7:0]       link_wdata
);
  initial begin
    link_wr    = 1'b0;
    link_addr  = 16'hFFFF;
    link_wdata = 8'hFF;
  end

  // One byte per strobe; bus inverted once released, never left stale
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    link_wr    = 1'b1;
    link_addr  = a;
    link_wdata = d;
    @(negedge clk);
    link_wr    = 1'b0;
    link_addr  = ~a;
    link_wdata = ~d;
  endtask
endmodule

// *** testbench/obcl_top_chk.sv ***
/*
 Port checker for the option byte loader top.
 Assumes it is bound to obcl_top and sees only its ports.
*/
`timescale 1ns/1ns
module obcl_top_chk (
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic        LINK_WR,
  input wire logic [15:0] LINK_ADDR,
  input wire logic [7:0]  LINK_WDATA,
  input wire logic        APP_WR,
  input wire logic [15:0] APP_ADDR,
  input wire logic [7:0]  APP_WDATA,
  input wire logic        RD_EN,
  input wire logic        UNLOCK_KEYS_OK,
  input wire logic        RD_VALID,
  input wire logic        CONFIG_LOADED,
  input wire logic        READOUT_PROTECT_ON,
  input wire logic [7:0]  BOOT_AREA_PAGES,
  input wire logic        PAGE_WRITE_LOCKED,
  input wire logic        INDEP_DOG_AUTO_START,
  input wire logic        INDEP_DOG_HALT_STOP,
  input wire logic        WINDOW_DOG_AUTO_START,
  input wire logic        WINDOW_DOG_HALT_RESET,
  input wire logic        BROWNOUT_ENABLE,
  input wire logic [2:0]  BROWNOUT_LEVEL_SELECT,
  input wire logic        BOOT_DECIDED
);
  // Writes count once loaded; app loses to a same-cycle link write
  wire       lw   = LINK_WR && CONFIG_LOADED;
  wire       aw   = APP_WR && !LINK_WR && CONFIG_LOADED;
  wire [3:0] dogs = {WINDOW_DOG_HALT_RESET, WINDOW_DOG_AUTO_START,
                     INDEP_DOG_HALT_STOP, INDEP_DOG_AUTO_START};
  wire [3:0] bor_in = {(LINK_WDATA[3:1] > 3'h4) ? 3'h4 : LINK_WDATA[3:1],
                       LINK_WDATA[0]};
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_read_answer: assert property (RD_EN |=> RD_VALID)
    else $error("read not answered next cycle");
  a_read_quiet: assert property (!RD_EN |=> !RD_VALID)
    else $error("read valid without request");
  a_rdp_open: assert property (lw && LINK_ADDR == 16'h4800 |=>
    READOUT_PROTECT_ON == ($past(LINK_WDATA) != 8'hAA))
    else $error("readout protection wrong after link write");
  a_app_rdp_held: assert property (aw &&
    (APP_ADDR == 16'h4800 || APP_ADDR == 16'h4802) |=>
    $stable(READOUT_PROTECT_ON) && $stable(BOOT_AREA_PAGES))
    else $error("application write changed protection");
  a_boot_small: assert property (lw && LINK_ADDR == 16'h4802 &&
    LINK_WDATA < 8'h7F |=> BOOT_AREA_PAGES == $past(LINK_WDATA))
    else $error("boot area size wrong");
  a_boot_all: assert property (lw && LINK_ADDR == 16'h4802 &&
    LINK_WDATA >= 8'h7F |=> BOOT_AREA_PAGES == 8'h80)
    else $error("boot area not all pages");
  a_dog_link: assert property (
    lw && LINK_ADDR == 16'h4808 |=>
    {4'h0, dogs} == ($past(LINK_WDATA) & 8'h0F))
    else $error("watchdog options wrong after link write");
  a_dog_app: assert property (aw && APP_ADDR == 16'h4808 |=>
    {4'h0, dogs} == ($past(APP_WDATA) & 8'h0F))
    else $error("watchdog options wrong after app write");
  a_bor_fields: assert property (
    lw && LINK_ADDR == 16'h480A |=>
    {BROWNOUT_LEVEL_SELECT, BROWNOUT_ENABLE} == $past(bor_in))
    else $error("brownout options wrong");
  a_keys_lock: assert property (CONFIG_LOADED && !UNLOCK_KEYS_OK |=>
    PAGE_WRITE_LOCKED)
    else $error("page unlocked without keys");
  a_boot_after_load: assert property (BOOT_DECIDED |-> CONFIG_LOADED)
    else $error("boot decided before options loaded");
  a_load_bounded: assert property ($fell(SYS_RST) |->
    ##[1:16] CONFIG_LOADED)
    else $error("options not loaded in time");
endmodule

bind obcl_top obcl_top_chk u_obcl_top_chk (
  .CLK(CLK), .SYS_RST(SYS_RST), .LINK_WR(LINK_WR), .LINK_ADDR(LINK_ADDR),
  .LINK_WDATA(LINK_WDATA), .APP_WR(APP_WR), .APP_ADDR(APP_ADDR),
  .APP_WDATA(APP_WDATA), .RD_EN(RD_EN), .UNLOCK_KEYS_OK(UNLOCK_KEYS_OK),
  .RD_VALID(RD_VALID), .CONFIG_LOADED(CONFIG_LOADED),
  .READOUT_PROTECT_ON(READOUT_PROTECT_ON), .BOOT_AREA_PAGES(BOOT_AREA_PAGES),
  .PAGE_WRITE_LOCKED(PAGE_WRITE_LOCKED),
  .INDEP_DOG_AUTO_START(INDEP_DOG_AUTO_START),
  .INDEP_DOG_HALT_STOP(INDEP_DOG_HALT_STOP),
  .WINDOW_DOG_AUTO_START(WINDOW_DOG_AUTO_START),
  .WINDOW_DOG_HALT_RESET(WINDOW_DOG_HALT_RESET),
  .BROWNOUT_ENABLE(BROWNOUT_ENABLE),
  .BROWNOUT_LEVEL_SELECT(BROWNOUT_LEVEL_SELECT), .BOOT_DECIDED(BOOT_DECIDED));

// *** testbench/tb_obcl_top.sv ***
/*
 Self-checking bench for the option byte loader top.
 Assumes the programmer model drives the link port.
*/
`timescale 1ns/1ns
module tb_obcl_top;
  logic        CLK, SYS_RST, LINK_WR, APP_WR, RD_EN, RD_FROM_LINK;
  logic        UNLOCK_KEYS_OK, FAST_OSC_ON, SLOW_OSC_ON;
  logic        FAST_OSC_PIN, SLOW_OSC_PIN, RD_VALID, CONFIG_LOADED;
  logic        READOUT_PROTECT_ON, PAGE_WRITE_LOCKED, BOOT_DECIDED;
  logic        INDEP_DOG_AUTO_START, INDEP_DOG_HALT_STOP, BOOT_TO_LOADER;
  logic        WINDOW_DOG_AUTO_START, WINDOW_DOG_HALT_RESET;
  logic        FAST_OSC_READY, SLOW_OSC_READY, BROWNOUT_ENABLE;
  logic [15:0] LINK_ADDR, APP_ADDR, RD_ADDR;
  logic [7:0]  LINK_WDATA, APP_WDATA, RESET_VECTOR_BYTE, RD_DATA;
  logic [7:0]  BOOT_AREA_PAGES, v, sz;
  logic [6:0]  PAGE_QUERY;
  logic [2:0]  BROWNOUT_LEVEL_SELECT;
  int          fails, checked, cycles;

  obcl_top u_obcl_top (.CLK(CLK), .SYS_RST(SYS_RST), .LINK_WR(LINK_WR),
    .LINK_ADDR(LINK_ADDR), .LINK_WDATA(LINK_WDATA), .APP_WR(APP_WR),
    .APP_ADDR(APP_ADDR), .APP_WDATA(APP_WDATA), .RD_EN(RD_EN),
    .RD_FROM_LINK(RD_FROM_LINK), .RD_ADDR(RD_ADDR),
    .RESET_VECTOR_BYTE(RESET_VECTOR_BYTE), .UNLOCK_KEYS_OK(UNLOCK_KEYS_OK),
    .PAGE_QUERY(PAGE_QUERY), .FAST_OSC_ON(FAST_OSC_ON),
    .SLOW_OSC_ON(SLOW_OSC_ON), .FAST_OSC_PIN(FAST_OSC_PIN),
    .SLOW_OSC_PIN(SLOW_OSC_PIN), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
    .CONFIG_LOADED(CONFIG_LOADED), .READOUT_PROTECT_ON(READOUT_PROTECT_ON),
    .BOOT_AREA_PAGES(BOOT_AREA_PAGES), .PAGE_WRITE_LOCKED(PAGE_WRITE_LOCKED),
    .INDEP_DOG_AUTO_START(INDEP_DOG_AUTO_START),
    .INDEP_DOG_HALT_STOP(INDEP_DOG_HALT_STOP),
    .WINDOW_DOG_AUTO_START(WINDOW_DOG_AUTO_START),
    .WINDOW_DOG_HALT_RESET(WINDOW_DOG_HALT_RESET),
    .FAST_OSC_READY(FAST_OSC_READY), .SLOW_OSC_READY(SLOW_OSC_READY),
    .BROWNOUT_ENABLE(BROWNOUT_ENABLE),
    .BROWNOUT_LEVEL_SELECT(BROWNOUT_LEVEL_SELECT),
    .BOOT_DECIDED(BOOT_DECIDED), .BOOT_TO_LOADER(BOOT_TO_LOADER));

  obcl_prog_model u_obcl_prog_model (.clk(CLK), .link_wr(LINK_WR),
    .link_addr(LINK_ADDR), .link_wdata(LINK_WDATA));

  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  // Longest part is the 4096-edge settle runs, about 33k cycles
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 90000) begin
      fails++;
      summarize();
    end
  end

  function automatic logic [7:0] pages_of(input logic [7:0] s);
    return (s >= 8'h7F) ? 8'h80 : s;
  endfunction

  function automatic logic [2:0] lvl_of(input logic [2:0] c);
    return (c > 3'h4) ? 3'h4 : c;
  endfunction

  task automatic summarize();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic lput(input logic [15:0] a, input logic [7:0] d);
    u_obcl_prog_model.put(a, d);
  endtask

  task automatic app_put(input logic [15:0] a, input logic [7:0] d);
    @(negedge CLK);
    APP_WR = 1'b1;
    APP_ADDR = a;
    APP_WDATA = d;
    @(negedge CLK);
    APP_WR = 1'b0;
    APP_ADDR = ~a;
    APP_WDATA = ~d;
  endtask

  task automatic rd(input logic [15:0] a, input logic lk,
                    input logic [7:0] e);
    @(negedge CLK);
    RD_EN = 1'b1;
    RD_ADDR = a;
    RD_FROM_LINK = lk;
    @(negedge CLK);
    RD_EN = 1'b0;
    RD_ADDR = ~a;
    chk("rd_valid", 16'h0001, {15'h0, RD_VALID});
    chk("rd_data", {8'h00, e}, {8'h00, RD_DATA});
  endtask

  task automatic do_reset();
    int k;
    SYS_RST = 1'b1;
    repeat (16) @(negedge CLK);
    SYS_RST = 1'b0;
    k = 0;
    while (BOOT_DECIDED !== 1'b1 && k < 40) begin
      @(negedge CLK);
      k++;
    end
    chk("boot_time", 16'h000E, 16'(k));
    chk("loaded", 16'h0003, {14'h0, CONFIG_LOADED, BOOT_DECIDED});
  endtask

  task automatic lock_chk(input logic [6:0] q, input logic e);
    @(negedge CLK);
    PAGE_QUERY = q;
    repeat (2) @(negedge CLK);
    chk("page_lock", {15'h0, e}, {15'h0, PAGE_WRITE_LOCKED});
  endtask

  // Pin rising edges four clocks apart, well below the sync limit
  task automatic pin_edge(input logic fast);
    @(negedge CLK);
    if (fast) FAST_OSC_PIN = 1'b1;
    else SLOW_OSC_PIN = 1'b1;
    repeat (2) @(negedge CLK);
    FAST_OSC_PIN = 1'b0;
    SLOW_OSC_PIN = 1'b0;
    @(negedge CLK);
  endtask

  task automatic settle(input logic fast, input logic [1:0] c);
    int n;
    n = (c == 2'h0) ? 1 : (c == 2'h1) ? 16 : (c == 2'h2) ? 512 : 4096;
    lput(16'h4809, fast ? {6'h00, c} : {4'h0, c, 2'h0});
    @(negedge CLK);
    FAST_OSC_ON = fast;
    SLOW_OSC_ON = !fast;
    repeat (n - 1) pin_edge(fast);
    repeat (6) @(negedge CLK);
    chk("osc_early", 16'h0000,
        {15'h0, fast ? FAST_OSC_READY : SLOW_OSC_READY});
    pin_edge(fast);
    repeat (5) @(negedge CLK);
    chk("osc_ready", 16'h0001,
        {15'h0, fast ? FAST_OSC_READY : SLOW_OSC_READY});
    FAST_OSC_ON = 1'b0;
    SLOW_OSC_ON = 1'b0;
    repeat (2) @(negedge CLK);
  endtask

  initial begin
    fails = 0;
    checked = 0;
    cycles = 0;
    v = 8'($urandom(32'h8A882997));
    SYS_RST = 1'b1;
    {APP_WR, RD_EN, RD_FROM_LINK, UNLOCK_KEYS_OK} = 4'h0;
    {FAST_OSC_ON, SLOW_OSC_ON, FAST_OSC_PIN, SLOW_OSC_PIN} = 4'h0;
    APP_ADDR = 16'h0000;
    APP_WDATA = 8'h00;
    RD_ADDR = 16'h0000;
    RESET_VECTOR_BYTE = 8'h82;
    PAGE_QUERY = 7'h00;
    do_reset();
    chk("loader", 16'h0000, {15'h0, BOOT_TO_LOADER});
    chk("rdp_on", 16'h0000, {15'h0, READOUT_PROTECT_ON});
    for (int i = 0; i < 13; i++) begin
      rd(16'h4800 + 16'(i), 1'b0, (i == 0) ? 8'hAA : 8'h00);
    end
    for (int i = 0; i < 16; i++) begin
      v = {4'($urandom), 4'(i)};
      lput(16'h4808, v);
      chk("dogs", {12'h000, v[3:0]}, {12'h000, WINDOW_DOG_HALT_RESET,
          WINDOW_DOG_AUTO_START, INDEP_DOG_HALT_STOP,
          INDEP_DOG_AUTO_START});
      lput(16'h480A, v);
      chk("bor", {12'h000, lvl_of(v[3:1]), v[0]}, {12'h000,
          BROWNOUT_LEVEL_SELECT, BROWNOUT_ENABLE});
      rd(16'h480A, 1'b1, v & 8'h0F);
    end
    UNLOCK_KEYS_OK = 1'b1;
    for (int i = 0; i < 10; i++) begin
      sz = (i < 4) ? 8'(i) : (i == 4) ? 8'h7E : (i == 5) ? 8'h7F :
           (i == 6) ? 8'hFF : 8'(4 + $urandom % 250);
      lput(16'h4802, sz);
      chk("pages", {8'h00, pages_of(sz)},
          {8'h00, BOOT_AREA_PAGES});
      if (sz != 8'h00) lock_chk(7'(pages_of(sz) - 8'h01), 1'b1);
      if (sz < 8'h7F) lock_chk(7'(sz), 1'b0);
    end
    lput(16'h4802, 8'h00);
    UNLOCK_KEYS_OK = 1'b0;
    lock_chk(7'h7F, 1'b1);
    UNLOCK_KEYS_OK = 1'b1;
    app_put(16'h4800, 8'h11);
    chk("rdp_app", 16'h0000, {15'h0, READOUT_PROTECT_ON});
    app_put(16'h4802, 8'h03);
    chk("pages_app", 16'h0000, {8'h00, BOOT_AREA_PAGES});
    app_put(16'h4808, 8'h0A);
    chk("dogs_app", 16'h000A, {12'h000, WINDOW_DOG_HALT_RESET,
        WINDOW_DOG_AUTO_START, INDEP_DOG_HALT_STOP,
        INDEP_DOG_AUTO_START});
    app_put(16'h480B, 8'h5A);
    app_put(16'h480C, 8'h5A);
    rd(16'h4800, 1'b0, 8'h11);
    do_reset();
    chk("rdp_reload", 16'h0001, {15'h0, READOUT_PROTECT_ON});
    chk("pages_reload", 16'h0003, {8'h00, BOOT_AREA_PAGES});
    chk("dog_kept", 16'h0001, {15'h0, WINDOW_DOG_HALT_RESET});
    chk("loader_word", 16'h0001, {15'h0, BOOT_TO_LOADER});
    rd(16'h4800, 1'b1, 8'h00);
    lput(16'h4800, 8'hAA);
    chk("rdp_open", 16'h0000, {15'h0, READOUT_PROTECT_ON});
    rd(16'h4800, 1'b1, 8'hAA);
    lput(16'h480B, 8'h00);
    RESET_VECTOR_BYTE = 8'h00;
    do_reset();
    chk("loader_blank", 16'h0001, {15'h0, BOOT_TO_LOADER});
    RESET_VECTOR_BYTE = 8'h82;
    do_reset();
    chk("loader_vec", 16'h0000, {15'h0, BOOT_TO_LOADER});
    for (int c = 0; c < 4; c++) begin
      settle(1'b1, 2'(c));
      settle(1'b0, 2'(c));
    end
    summarize();
  end
endmodule
